// ==== hdl/lasp_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lasp_host
	import lasp_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	output logic req_ready_o,
	output logic [DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic mem_ale_o,
	output logic mem_ce_n_o,
	output logic mem_oe_n_o,
	output logic mem_we_n_o,
	input wire logic [DATA_W-1:0] mem_dq_i,
	output logic [DATA_W-1:0] mem_dq_o,
	output logic mem_dq_oe_o
);
	lasp_regs_t r_ff;
	lasp_regs_t nxt_r;

	// Sequencer: latch address, then read wait or write pulse
	always_comb begin
		nxt_r = r_ff;
		nxt_r.s1 = mem_dq_i;
		nxt_r.s2 = r_ff.s1;
		nxt_r.rvalid = 1'b0;
		nxt_r.cnt = (r_ff.cnt > 4'h0) ? r_ff.cnt - CNT_ONE : 4'h0;
		unique case (r_ff.st)
			LASP_IDLE: begin
				// Taken only while idle; a request while busy is simply not seen
				if (req_i && r_ff.ready) begin
					nxt_r.ready = 1'b0;
					nxt_r.wr = req_write_i;
					// Address moves only with both enables high [R2]
					nxt_r.pin.addr = req_addr_i;
					nxt_r.pin.dq_o = req_wdata_i;
					nxt_r.pin.ale = 1'b0;
					nxt_r.cnt = 4'(STROBE_CYC);
					nxt_r.st = LASP_LATCH;
				end
			end
			LASP_LATCH: begin
				// Strobe stays low a full setup time, so the latch never opens on a
				// half-settled address; costs a few cycles on every access
				if (r_ff.cnt == 4'h0) begin
					// Rising strobe starts access timing [R4] [R7]
					nxt_r.pin.ale = 1'b1;
					nxt_r.cnt = 4'(STROBE_CYC);
					nxt_r.st = LASP_HOLD;
				end
			end
			LASP_HOLD: begin
				if (r_ff.cnt == 4'h0) begin
					// Strobe closes as the chip is enabled, so the memory works from the latch
					nxt_r.pin.ale = 1'b0;
					nxt_r.pin.ce_n = 1'b0;
					if (r_ff.wr) begin
						// Output enable stays high, so no bus fight [R8] [R11]
						nxt_r.pin.we_n = 1'b0;
						nxt_r.pin.dq_oe = 1'b1;
						nxt_r.cnt = 4'(PULSE_CYC);
						nxt_r.st = LASP_WRPULSE;
					end else begin
						// Write enable held high all read [R1] [R10]
						nxt_r.pin.oe_n = 1'b0;
						nxt_r.cnt = 4'(ACCESS_CYC);
						nxt_r.st = LASP_RDWAIT;
					end
				end
			end
			LASP_RDWAIT: begin
				// Sample after access time plus synchroniser depth [R5]
				// Fixed wait: the memory gives no ready, so there is no early exit
				if (r_ff.cnt == 4'h0) begin
					nxt_r.rdata = r_ff.s2;
					nxt_r.rvalid = 1'b1;
					nxt_r.pin.oe_n = 1'b1;
					nxt_r.pin.ce_n = 1'b1;
					nxt_r.cnt = 4'(TURN_CYC);
					nxt_r.st = LASP_TURN;
				end
			end
			LASP_WRPULSE: begin
				// Pulse covers turn-off plus data setup [R9]; ends on both enables [R6] [R3]
				// Output enable is high, so the plain minimum would do; the longer
				// figure is kept as margin should output enable ever be left low
				if (r_ff.cnt == 4'h0) begin
					nxt_r.pin.we_n = 1'b1;
					nxt_r.pin.ce_n = 1'b1;
					nxt_r.cnt = 4'(LOW_CYC);
					nxt_r.st = LASP_TURN;
				end
			end
			LASP_TURN: begin
				// A new request waits here, which keeps chip enable high between accesses
				// Data held one more cycle after write end, then released
				nxt_r.pin.dq_oe = 1'b0;
				if (r_ff.cnt == 4'h0) begin
					nxt_r.ready = 1'b1;
					nxt_r.st = LASP_IDLE;
				end
			end
			default: nxt_r.st = LASP_IDLE;
		endcase
	end

	// State register; idle pins leave the memory floating [R13]
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			// Every pin starts at its idle level, so reset never looks like an access
			r_ff <= '0;
			r_ff.st <= LASP_IDLE;
			r_ff.ready <= 1'b1;
			r_ff.pin.ce_n <= 1'b1;
			r_ff.pin.oe_n <= 1'b1;
			r_ff.pin.we_n <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Pins and answers come straight from the state register
	assign req_ready_o = r_ff.ready;
	assign rdata_o = r_ff.rdata;
	assign rvalid_o = r_ff.rvalid;
	assign mem_addr_o = r_ff.pin.addr;
	assign mem_ale_o = r_ff.pin.ale;
	assign mem_ce_n_o = r_ff.pin.ce_n;
	assign mem_oe_n_o = r_ff.pin.oe_n;
	assign mem_we_n_o = r_ff.pin.we_n;
	assign mem_dq_o = r_ff.pin.dq_o;
	assign mem_dq_oe_o = r_ff.pin.dq_oe;

	// Helper for the pulse-width check: cycles spent with write enable low
	int pulse_len_ff;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) pulse_len_ff <= 0;
		else if (!r_ff.pin.we_n) pulse_len_ff <= pulse_len_ff + 1;
		else pulse_len_ff <= 0;
	end

	// Steps of one access, shared by the properties below
	sequence lasp_strobe_rise_s;
		$rose(r_ff.pin.ale);
	endsequence

	sequence lasp_write_open_s;
		$fell(r_ff.pin.we_n) ##0 (!r_ff.pin.ce_n && r_ff.pin.oe_n);
	endsequence

	sequence lasp_write_close_s;
		$rose(r_ff.pin.we_n) ##0 r_ff.pin.ce_n;
	endsequence

	sequence lasp_read_open_s;
		$fell(r_ff.pin.oe_n) ##0 (!r_ff.pin.ce_n && r_ff.pin.we_n);
	endsequence

	// Pin discipline
	AST_READ_WE_HIGH: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
		!r_ff.pin.oe_n |-> r_ff.pin.we_n) else $error("write enable low during read");
	AST_ADDR_STABLE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
		$changed(r_ff.pin.addr) |-> r_ff.pin.we_n && r_ff.pin.ce_n)
		else $error("address moved while enabled");
	AST_NO_FIGHT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R8]
		r_ff.pin.dq_oe |-> r_ff.pin.oe_n) else $error("bus driven with output enable low");
	AST_PULSE_LEN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R9]
		$rose(r_ff.pin.we_n) |-> $past(pulse_len_ff) >= PULSE_CYC)
		else $error("write pulse too short");
	AST_WRITE_END: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R6]
		$rose(r_ff.pin.we_n) |-> r_ff.pin.ce_n && r_ff.st == LASP_TURN)
		else $error("write did not end cleanly");
	AST_STROBE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R7]
		lasp_strobe_rise_s |-> r_ff.pin.ale [*2]) else $error("strobe high too short");
	AST_RVALID: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R4]
		$fell(r_ff.pin.oe_n) |-> ##[1:8] r_ff.rvalid) else $error("read answer late");
	AST_IDLE_FLOAT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R13]
		r_ff.st == LASP_IDLE |-> r_ff.pin.ce_n && !r_ff.pin.dq_oe)
		else $error("idle not floating");

	// Access shape on the pins
	AST_WRITE_PULSE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R9]
		lasp_write_open_s |-> (!r_ff.pin.we_n && r_ff.pin.dq_oe && r_ff.pin.oe_n) [*3])
		else $error("write pulse broken early");
	AST_DATA_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R6]
		lasp_write_close_s |-> r_ff.pin.dq_oe ##1 !r_ff.pin.dq_oe)
		else $error("write data not held past write end");
	AST_READ_SPAN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
		lasp_read_open_s |-> (!r_ff.pin.oe_n && r_ff.pin.we_n) [*6] ##1
		(r_ff.pin.oe_n && r_ff.rvalid)) else $error("read span wrong");
	AST_ONE_ACCESS: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R8]
		!r_ff.pin.ce_n |-> (r_ff.pin.oe_n != r_ff.pin.we_n))
		else $error("chip enabled without exactly one of read or write");

	// Strobe and address
	AST_STROBE_CLOSED: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
		!r_ff.pin.ce_n |-> !r_ff.pin.ale && $stable(r_ff.pin.addr))
		else $error("strobe open or address moving during access");
	AST_ADDR_SETUP: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
		lasp_strobe_rise_s |-> $stable(r_ff.pin.addr) && r_ff.pin.ce_n)
		else $error("address not settled at strobe rise");
	AST_LATCH_LOW: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
		r_ff.st == LASP_LATCH |-> !r_ff.pin.ale && r_ff.pin.ce_n && r_ff.pin.we_n)
		else $error("strobe or enable active during address setup");

	// Handshake
	AST_RVALID_PULSE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R10]
		r_ff.rvalid |=> !r_ff.rvalid && r_ff.pin.oe_n)
		else $error("read answer longer than one cycle");
	AST_READY_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R13]
		r_ff.ready |-> r_ff.st == LASP_IDLE && r_ff.pin.ce_n && !r_ff.pin.dq_oe)
		else $error("ready raised while busy");
	AST_RECOVERY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R6]
		$rose(r_ff.pin.ce_n) |-> r_ff.pin.ce_n [*2])
		else $error("chip enable high too briefly after an access");
endmodule : lasp_host
`default_nettype wire

// ==== hdl/lasp_pkg.sv ====
// Notes on behaviour
// (R1) Write enable stays high for the whole of every read access.
// (R2) The address only changes while write enable or chip enable is high.
// (R3) The memory stores data only while chip enable and write enable are both low.
// (R4) Read access time counts from the strobe rise after a valid address.
// (R5) Old read data may stay on the pins until the strobe rises on a new address.
// (R6) A write ends when chip enable or write enable first returns high.
// (R7) Write address setup counts from the first strobe rise after the address is valid.
// (R8) The host drives the data bus only once the memory drivers are off.
// (R9) With output enable low the write pulse covers driver turn-off plus data setup.
// (R10) With chip and output enable low and write enable high the memory drives data.
// (R11) With chip and write enable low the memory writes bus data, output enable ignored.
// (R12) Each word is nine bits wide and the array holds 8192 words.
// (R13) With chip enable high, or output and write enable high, the data pins float.
`default_nettype none
package lasp_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 9;
	localparam int CLK_PERIOD_PS = 5000;
	// Timing figures in ps, fastest grade
	localparam int ADDRESS_ACCESS_INTERVAL_PS = 12000;
	localparam int STROBE_HIGH_PS = 6000;
	localparam int STROBE_LOW_PS = 6000;
	localparam int ADDR_SETUP_PS = 3000;
	localparam int WRITE_PULSE_PS = 9000;
	localparam int WE_TO_HIGHZ_PS = 6000;
	localparam int DATA_SETUP_TO_WRITE_END_PS = 6000;
	localparam int OE_TO_HIGHZ_PS = 5000;
	function automatic int cyc_up(input int ps);
		return (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1 ? 1 :
			(ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	endfunction
	localparam int ACCESS_CYC = cyc_up(ADDRESS_ACCESS_INTERVAL_PS) + 2;
	localparam int STROBE_CYC = cyc_up(STROBE_HIGH_PS > ADDR_SETUP_PS ? STROBE_HIGH_PS :
		ADDR_SETUP_PS);
	localparam int LOW_CYC = cyc_up(STROBE_LOW_PS);
	localparam int PULSE_CYC = cyc_up(WRITE_PULSE_PS) > cyc_up(WE_TO_HIGHZ_PS +
		DATA_SETUP_TO_WRITE_END_PS) ? cyc_up(WRITE_PULSE_PS) :
		cyc_up(WE_TO_HIGHZ_PS + DATA_SETUP_TO_WRITE_END_PS);
	localparam int TURN_CYC = cyc_up(OE_TO_HIGHZ_PS);
	localparam logic [3:0] CNT_ONE = 4'h1;
	typedef enum logic [5:0] {
		LASP_IDLE = 6'h01,
		LASP_LATCH = 6'h02,
		LASP_HOLD = 6'h04,
		LASP_RDWAIT = 6'h08,
		LASP_WRPULSE = 6'h10,
		LASP_TURN = 6'h20
	} lasp_state_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic ale;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [DATA_W-1:0] dq_o;
		logic dq_oe;
	} lasp_pins_t;
	typedef struct packed {
		lasp_state_t st;
		logic [3:0] cnt;
		logic wr;
		lasp_pins_t pin;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic ready;
		logic [DATA_W-1:0] s1;
		logic [DATA_W-1:0] s2;
	} lasp_regs_t;
endpackage : lasp_pkg
`default_nettype wire

// ==== testbench/lasp_sram_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module lasp_sram_model
	import lasp_pkg::*;
(
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic ale_i,
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [DATA_W-1:0] din_i,
	output logic drv_o,
	output logic [DATA_W-1:0] dout_o
);
	logic [DATA_W-1:0] mem [0:8191];
	logic [ADDR_W-1:0] lat;
	logic [ADDR_W-1:0] eff;
	logic [DATA_W-1:0] rd;
	// Latch is open while the strobe is high
	always_latch begin
		if (ale_i) lat <= addr_i;
	end
	assign eff = ale_i ? addr_i : lat;
	// Store over the enable overlap; output enable plays no part
	always @(*) begin
		if (!ce_n_i && !we_n_i) mem[eff] = din_i;
	end
	// Slow on purpose: data settles only after the access interval
	assign #(ADDRESS_ACCESS_INTERVAL_PS / 1000) rd = mem[eff];
	assign drv_o = !ce_n_i && !oe_n_i && we_n_i;
	assign dout_o = drv_o ? rd : ~rd; // Released bus shows no stale value
endmodule // lasp_sram_model
`default_nettype wire

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
	import lasp_pkg::*;
	logic clk_i = 0, reset_n_i = 0, req_i = 0, req_write_i = 0;
	logic [ADDR_W-1:0] req_addr_i = 0, mem_addr_o, pa;
	logic [DATA_W-1:0] req_wdata_i = 0, rdata_o, mem_dq_o, mem_dq_i, dout;
	logic req_ready_o, rvalid_o, mem_ale_o, mem_ce_n_o, mem_oe_n_o, mem_we_n_o;
	logic mem_dq_oe_o, drv, wr_p = 0;
	logic [DATA_W-1:0] ref_mem [0:8191];
	logic [ADDR_W-1:0] aq [$];
	int fails = 0, n_checks = 0, wl = 0, al = 0;
	always #2.5 clk_i = ~clk_i;
	lasp_host dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
		.req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
		.req_ready_o(req_ready_o), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.mem_addr_o(mem_addr_o), .mem_ale_o(mem_ale_o), .mem_ce_n_o(mem_ce_n_o),
		.mem_oe_n_o(mem_oe_n_o), .mem_we_n_o(mem_we_n_o), .mem_dq_i(mem_dq_i),
		.mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o));
	lasp_sram_model mdl (.addr_i(mem_addr_o), .ale_i(mem_ale_o), .ce_n_i(mem_ce_n_o),
		.oe_n_i(mem_oe_n_o), .we_n_i(mem_we_n_o), .din_i(mem_dq_i), .drv_o(drv),
		.dout_o(dout));
	assign mem_dq_i = mem_dq_oe_o ? mem_dq_o : dout; // Shared bus level
	task automatic check(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Expected word: the last value written to that address
	function automatic logic [DATA_W-1:0] exp_word(input logic [ADDR_W-1:0] a);
		return ref_mem[a];
	endfunction
	// One request, held until taken; reads compared with the reference
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		#1;
		req_i = 1;
		req_write_i = w;
		req_addr_i = a;
		req_wdata_i = d;
		while (req_ready_o !== 1'b1) begin
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		#1;
		req_i = 0;
		if (w) ref_mem[a] = d;
		else begin
			while (rvalid_o !== 1'b1 && n < 40) begin
				@(posedge clk_i);
				#1;
				n++;
			end
			check(16'(rvalid_o), 16'h1);
			check(16'(rdata_o), 16'(exp_word(a)));
		end
	endtask
	// Pin discipline watched on the falling edge, when outputs are settled
	always @(negedge clk_i) begin
		if (reset_n_i) begin
			if (!mem_ce_n_o && !mem_oe_n_o) check(16'(mem_we_n_o), 16'h1);
			if (mem_dq_oe_o) check(16'(drv), 16'h0);
			if (!mem_ce_n_o && !mem_we_n_o && wr_p) check(16'(mem_addr_o), 16'(pa));
			if (mem_we_n_o && wl > 0) check(16'(wl >= cyc_up(WRITE_PULSE_PS)), 16'h1);
			// Strobe pulse long enough, address still while it is open
			if (!mem_ale_o && al > 0) check(16'(al >= cyc_up(STROBE_HIGH_PS)), 16'h1);
			if (mem_ale_o && al > 0) check(16'(mem_addr_o), 16'(pa));
			wl = mem_we_n_o ? 0 : wl + 1;
			al = mem_ale_o ? al + 1 : 0;
			wr_p = !mem_ce_n_o && !mem_we_n_o;
			pa = mem_addr_o;
		end
	end
	// Watchdog, well beyond the expected run length
	initial begin
		#200000;
		fails++;
		print_verdict();
	end
	initial begin
		logic [ADDR_W-1:0] a;
		void'($urandom(32'h1fb1));
		repeat (12) @(posedge clk_i);
		#1;
		check(16'({req_ready_o, mem_ce_n_o, mem_we_n_o, mem_dq_oe_o}), 16'he);
		reset_n_i = 1;
		// Boundary addresses, all-ones and all-zeros words, overwrite
		xfer(1, 13'h0000, 9'h1ff);
		xfer(1, 13'h1fff, 9'h000);
		xfer(1, 13'h1fff, 9'h155);
		xfer(0, 13'h0000, 9'h000);
		xfer(0, 13'h1fff, 9'h000);
		// Random writes, each read back later
		repeat (40) begin
			a = 13'($urandom);
			aq.push_back(a);
			xfer(1, a, 9'($urandom));
		end
		foreach (aq[i]) xfer(0, aq[i], 9'h000);
		print_verdict();
	end
endmodule // tb
`default_nettype wire
